//--- pkg/sem_cycle_if.sv
// Request and answer signals for one semaphore bus cycle.
`timescale 1ns/10ps
`default_nettype none
`include "sem_host_cfg.svh"

interface sem_cycle_if;
    logic req;
    logic write;
    logic [`SEM_INDEX_W-1:0] index;
    logic wdata;
    logic ready;
    logic ack;
    logic rdata;

    modport ctrl (
        output req,
        output write,
        output index,
        output wdata,
        input ready,
        input ack,
        input rdata
    );

    modport unit (
        input req,
        input write,
        input index,
        input wdata,
        output ready,
        output ack,
        output rdata
    );
endinterface : sem_cycle_if

`default_nettype wire

//--- pkg/sem_host_cfg.svh
// Constants for the semaphore flag controller.
`ifndef SEM_HOST_CFG_SVH
`define SEM_HOST_CFG_SVH

`define SEM_FLAG_COUNT 8
`define SEM_INDEX_W 3
`define SEM_LAST_INDEX 3'h7
`define SEM_DATA_W 16
`define SEM_CLK_PERIOD_NS 40
`define SEM_ACCESS_NS 55
`define SEM_ACCESS_CYC ((`SEM_ACCESS_NS + `SEM_CLK_PERIOD_NS - 1) / `SEM_CLK_PERIOD_NS)
`define SEM_FLAG_FREE 1'h1
`define SEM_FLAG_TAKE 1'h0

`endif

//--- pkg/sem_host_pkg.sv
// Types for the semaphore flag controller.
`include "sem_host_cfg.svh"

package sem_host_pkg;

    typedef enum logic {
        cmd_acquire,
        cmd_release
    } sem_cmd_t;

    typedef enum {
        cyc_idle,
        cyc_active,
        cyc_recover
    } cycle_state_t;

    typedef enum {
        st_init,
        st_idle,
        st_acq_wr,
        st_acq_rd,
        st_rel_wr
    } host_state_t;

endpackage : sem_host_pkg

//--- rtl/sem_bus_cycle.sv
// Pin sequencer that runs one semaphore read or write cycle.
`timescale 1ns/10ps
`default_nettype none
`include "sem_host_cfg.svh"

module sem_bus_cycle (
    input wire logic i_clk,
    input wire logic i_srst,
    sem_cycle_if.unit cyc,
    output logic o_sem_n,
    output logic [`SEM_INDEX_W-1:0] o_flag_index_lines,
    output logic o_oe_n,
    output logic o_rw_n,
    output logic [`SEM_DATA_W-1:0] o_data,
    output logic o_data_oe,
    input wire logic [`SEM_DATA_W-1:0] i_data
);

    // ----------------------------------------------------------------
    // Cycle sequencing
    // ----------------------------------------------------------------
    sem_host_pkg::cycle_state_t state;
    logic [3:0] count;

    assign cyc.ready = (state == sem_host_pkg::cyc_idle);

    // R3: Static memory cycle.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= sem_host_pkg::cyc_idle;
            count <= 4'h0;
            o_sem_n <= 1'h1;
            o_oe_n <= 1'h1;
            o_rw_n <= 1'h1;
            o_data_oe <= 1'h0;
            o_data <= 16'h0000;
            o_flag_index_lines <= 3'h0;
            cyc.ack <= 1'h0;
            cyc.rdata <= 1'h1;
        end else begin
            cyc.ack <= 1'h0;
            unique case (state)
                sem_host_pkg::cyc_idle: begin
                    if (cyc.req) begin
                        state <= sem_host_pkg::cyc_active;
                        count <= 4'h0;
                        o_sem_n <= 1'h0;
                        o_flag_index_lines <= cyc.index;
                        o_rw_n <= ~cyc.write;
                        o_oe_n <= cyc.write;
                        o_data_oe <= cyc.write;
                        o_data <= {`SEM_DATA_W{cyc.wdata}};
                    end
                end
                sem_host_pkg::cyc_active: begin
                    count <= count + 4'h1;
                    if (count == 4'(`SEM_ACCESS_CYC - 1)) begin
                        state <= sem_host_pkg::cyc_recover;
                        cyc.ack <= 1'h1;
                        if (!o_oe_n) begin
                            cyc.rdata <= i_data[0];
                        end
                        // R13: Deselect between reads.
                        o_sem_n <= 1'h1;
                        o_oe_n <= 1'h1;
                        o_rw_n <= 1'h1;
                    end
                end
                sem_host_pkg::cyc_recover: begin
                    o_data_oe <= 1'h0;
                    state <= sem_host_pkg::cyc_idle;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_strobe_in_space;
        @(posedge i_clk) disable iff (i_srst)
        (!o_oe_n || !o_rw_n) |-> !o_sem_n;
    endproperty
    a_strobe_in_space: assert property (p_strobe_in_space) else $error("Strobe outside semaphore select."); // R3

    property p_deselect_after;
        @(posedge i_clk) disable iff (i_srst)
        cyc.ack |-> o_sem_n && o_oe_n ##1 o_sem_n;
    endproperty
    a_deselect_after: assert property (p_deselect_after) else $error("No deselect between cycles."); // R13

endmodule : sem_bus_cycle

`default_nettype wire

//--- rtl/sem_host.sv
// Controller that acquires and releases semaphore flags of a dual-port memory.
// ------------------------------------------------------------------------
// Summary of operation
// R1: Device holds eight flags apart from memory.
// R2: Write zero requests, write one releases.
// R3: Select low, then ordinary read/write strobes.
// R4: Device decodes only three index lines.
// R5: Device uses only lowest data bit.
// R6: Winner reads zero, other side reads one.
// R7: Only holder changes a held flag.
// R8: Holder writing one frees the flag.
// R9: Loser's zero waits in its request latch.
// R10: Pending request takes over on release.
// R11: Read flag spreads over all data bits.
// R12: Read value frozen while read is active.
// R13: Deselect between repeated polling reads.
// R14: Acquire writes zero, then reads back.
// R15: After failure, poll or withdraw with one.
// R16: First zero latch owns until written one.
// R17: Simultaneous requests granted to one port.
// R18: Write one to all flags at start.
// R19: Device flags unknown until written one.
// ------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "sem_host_cfg.svh"

module sem_host (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cmd_valid,
    input wire sem_host_pkg::sem_cmd_t i_cmd,
    input wire logic [`SEM_INDEX_W-1:0] i_cmd_index,
    input wire logic i_wait_on_fail,
    input wire logic i_cancel,
    output logic o_cmd_ready,
    output logic o_done,
    output logic o_granted,
    output logic [`SEM_FLAG_COUNT-1:0] o_held,
    output logic o_sem_n,
    output logic [`SEM_INDEX_W-1:0] o_flag_index_lines,
    output logic o_oe_n,
    output logic o_rw_n,
    output logic [`SEM_DATA_W-1:0] o_data,
    output logic o_data_oe,
    input wire logic [`SEM_DATA_W-1:0] i_data
);

    // ------------------------------------------------------------------------
    // Bus cycle unit
    // ------------------------------------------------------------------------
    sem_cycle_if cyc ();

    sem_bus_cycle u_cycle (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .cyc(cyc),
        .o_sem_n(o_sem_n),
        .o_flag_index_lines(o_flag_index_lines),
        .o_oe_n(o_oe_n),
        .o_rw_n(o_rw_n),
        .o_data(o_data),
        .o_data_oe(o_data_oe),
        .i_data(i_data)
    );

    // ------------------------------------------------------------------------
    // Sequencing state
    // ------------------------------------------------------------------------
    sem_host_pkg::host_state_t state;
    logic [`SEM_INDEX_W-1:0] cur_index;
    logic pending;
    logic [3:0] init_writes;
    logic fail;

    assign fail = (state == sem_host_pkg::st_acq_rd) && cyc.ack && cyc.rdata;
    assign o_cmd_ready = (state == sem_host_pkg::st_idle);
    assign cyc.req = !pending && (state != sem_host_pkg::st_idle);
    assign cyc.write = (state != sem_host_pkg::st_acq_rd);
    assign cyc.index = cur_index;
    // R2: Zero requests, one releases.
    assign cyc.wdata = (state == sem_host_pkg::st_acq_wr) ? `SEM_FLAG_TAKE : `SEM_FLAG_FREE;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pending <= 1'h0;
        end else if (cyc.ack) begin
            pending <= 1'h0;
        end else if (cyc.req && cyc.ready) begin
            pending <= 1'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= sem_host_pkg::st_init;
            cur_index <= 3'h0;
        end else begin
            unique case (state)
                // R18: Free every flag.
                sem_host_pkg::st_init: begin
                    if (cyc.ack) begin
                        cur_index <= cur_index + 3'h1;
                        if (cur_index == `SEM_LAST_INDEX) begin
                            state <= sem_host_pkg::st_idle;
                        end
                    end
                end
                sem_host_pkg::st_idle: begin
                    if (i_cmd_valid) begin
                        cur_index <= i_cmd_index;
                        state <= (i_cmd == sem_host_pkg::cmd_acquire) ? sem_host_pkg::st_acq_wr :
                            sem_host_pkg::st_rel_wr;
                    end
                end
                // R14: Write before read.
                sem_host_pkg::st_acq_wr: begin
                    if (cyc.ack) begin
                        state <= sem_host_pkg::st_acq_rd;
                    end
                end
                sem_host_pkg::st_acq_rd: begin
                    if (cyc.ack) begin
                        // R15: Poll again or withdraw.
                        if (!cyc.rdata) begin
                            state <= sem_host_pkg::st_idle;
                        end else if (!i_wait_on_fail || i_cancel) begin
                            state <= sem_host_pkg::st_rel_wr;
                        end
                    end
                end
                sem_host_pkg::st_rel_wr: begin
                    if (cyc.ack) begin
                        state <= sem_host_pkg::st_idle;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Results
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_done <= 1'h0;
            o_granted <= 1'h0;
            o_held <= 8'h00;
        end else begin
            o_done <= 1'h0;
            if (state == sem_host_pkg::st_acq_rd && cyc.ack && !cyc.rdata) begin
                o_done <= 1'h1;
                o_granted <= 1'h1;
                o_held[cur_index] <= 1'h1;
            end else if (state == sem_host_pkg::st_rel_wr && cyc.ack) begin
                o_done <= 1'h1;
                o_granted <= 1'h0;
                o_held[cur_index] <= 1'h0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            init_writes <= 4'h0;
        end else if (state == sem_host_pkg::st_init && cyc.ack) begin
            init_writes <= init_writes + 4'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_write_value;
        @(posedge i_clk) disable iff (i_srst)
        (!o_sem_n && !o_rw_n) |-> o_data_oe && ((o_data == 16'h0000) == (state == sem_host_pkg::st_acq_wr));
    endproperty
    a_write_value: assert property (p_write_value) else $error("Wrong semaphore write value."); // R2

    property p_write_then_read;
        @(posedge i_clk) disable iff (i_srst)
        (state == sem_host_pkg::st_acq_rd && $past(state) != sem_host_pkg::st_acq_rd) |->
            $past(state) == sem_host_pkg::st_acq_wr;
    endproperty
    a_write_then_read: assert property (p_write_then_read) else $error("Acquire read without prior write."); // R14

    property p_fail_followup;
        @(posedge i_clk) disable iff (i_srst)
        fail |=> (state == sem_host_pkg::st_acq_rd || state == sem_host_pkg::st_rel_wr) ##[1:6] cyc.ack;
    endproperty
    a_fail_followup: assert property (p_fail_followup) else $error("Failed request left hanging."); // R15

    property p_init_all;
        @(posedge i_clk) disable iff (i_srst)
        o_cmd_ready |-> init_writes == 4'h8;
    endproperty
    a_init_all: assert property (p_init_all) else $error("Ready before all flags freed."); // R18

    property p_poll_deselect;
        @(posedge i_clk) disable iff (i_srst)
        (state == sem_host_pkg::st_acq_rd && cyc.ack) |-> o_sem_n [*2];
    endproperty
    a_poll_deselect: assert property (p_poll_deselect) else $error("Select held across polls."); // R13

    c_grant: cover property (@(posedge i_clk) disable iff (i_srst) o_done && o_granted);
    c_poll: cover property (@(posedge i_clk) disable iff (i_srst) fail ##1 state == sem_host_pkg::st_acq_rd);
    c_withdraw: cover property (@(posedge i_clk) disable iff (i_srst) fail ##1 state == sem_host_pkg::st_rel_wr);
    c_release: cover property (@(posedge i_clk) disable iff (i_srst) o_done && !o_granted);

endmodule : sem_host

`default_nettype wire

//--- verification/sem_flag_model.sv
// Behavioural model of the eight dual-port semaphore flags.
`timescale 1ns/10ps
`default_nettype none

module sem_flag_model (
    input wire logic i_sem_l_n,
    input wire logic [2:0] i_idx_l,
    input wire logic i_oe_l_n,
    input wire logic i_rw_l_n,
    input wire logic [15:0] i_data_l,
    output logic [15:0] o_data_l,
    input wire logic i_sem_r_n,
    input wire logic [2:0] i_idx_r,
    input wire logic i_oe_r_n,
    input wire logic i_rw_r_n,
    input wire logic [15:0] i_data_r,
    output logic [15:0] o_data_r
);
    logic [7:0] req_l;
    logic [7:0] req_r;
    logic [7:0][1:0] owner;
    logic cap_l;
    logic cap_r;

    always @* begin
        for (int i = 0; i < 8; i++) begin
            if (!i_sem_l_n && !i_rw_l_n && i_idx_l == i[2:0]) req_l[i] = i_data_l[0];
            if (!i_sem_r_n && !i_rw_r_n && i_idx_r == i[2:0]) req_r[i] = i_data_r[0];
            if (req_l[i] === 1'b1 && req_r[i] === 1'b1) owner[i] = 2'h0;
            if (owner[i] == 2'h1 && req_l[i] == 1'b1) owner[i] = 2'h0;
            if (owner[i] == 2'h2 && req_r[i] == 1'b1) owner[i] = 2'h0;
            if (owner[i] == 2'h0) begin
                if (req_l[i] == 1'b0) owner[i] = 2'h1;
                else if (req_r[i] == 1'b0) owner[i] = 2'h2;
            end
        end
    end

    always @(negedge (i_sem_l_n | i_oe_l_n)) #1 cap_l = (owner[i_idx_l] != 2'h1);
    always @(negedge (i_sem_r_n | i_oe_r_n)) #1 cap_r = (owner[i_idx_r] != 2'h2);

    assign o_data_l = (!i_sem_l_n && !i_oe_l_n) ? {16{cap_l}} : ~{16{cap_l}};
    assign o_data_r = (!i_sem_r_n && !i_oe_r_n) ? {16{cap_r}} : ~{16{cap_r}};
endmodule : sem_flag_model

`default_nettype wire

//--- verification/tb_top.sv
// Testbench for the semaphore flag controller.
`timescale 1ns/10ps
`default_nettype none
`include "sem_host_cfg.svh"

module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    sem_host_pkg::sem_cmd_t cmd = sem_host_pkg::cmd_acquire;
    logic [2:0] cmd_index = 3'h0;
    logic wait_on_fail = 1'b0;
    logic cancel = 1'b0;
    logic cmd_ready, done, granted, sem_n, oe_n, rw_n, data_oe;
    logic [7:0] held;
    logic [2:0] idx;
    logic [15:0] data, dev_l, dq_l, dq_r;
    logic sem_r_n = 1'b1;
    logic oe_r_n = 1'b1;
    logic rw_r_n = 1'b1;
    logic [2:0] idx_r = 3'h0;
    logic [15:0] data_r = 16'h0000;
    logic [15:0] q;
    logic ok;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;

    assign dq_l = data_oe ? data : dev_l;

    sem_host dut (.i_clk(clk), .i_srst(srst), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_cmd_index(cmd_index),
        .i_wait_on_fail(wait_on_fail), .i_cancel(cancel), .o_cmd_ready(cmd_ready), .o_done(done),
        .o_granted(granted), .o_held(held), .o_sem_n(sem_n), .o_flag_index_lines(idx), .o_oe_n(oe_n),
        .o_rw_n(rw_n), .o_data(data), .o_data_oe(data_oe), .i_data(dq_l));

    sem_flag_model partner (.i_sem_l_n(sem_n), .i_idx_l(idx), .i_oe_l_n(oe_n), .i_rw_l_n(rw_n),
        .i_data_l(data), .o_data_l(dev_l), .i_sem_r_n(sem_r_n), .i_idx_r(idx_r), .i_oe_r_n(oe_r_n),
        .i_rw_r_n(rw_r_n), .i_data_r(data_r), .o_data_r(dq_r));

    always #20 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic chk_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : chk_word

    task automatic issue(input sem_host_pkg::sem_cmd_t c, input logic [2:0] i, input logic wt);
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        wait_on_fail = wt;
        cmd = c;
        cmd_index = i;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : issue

    task automatic wait_done(input int lim);
        int n;
        n = 0;
        ok = 1'b0;
        while (!ok && n < lim) begin
            if (done === 1'b1) ok = 1'b1;
            else begin
                @(negedge clk);
                n++;
            end
        end
    endtask : wait_done

    task automatic do_cmd(input sem_host_pkg::sem_cmd_t c, input logic [2:0] i, input logic exp);
        issue(c, i, 1'b0);
        wait_done(60);
        chk_bit(ok, 1'b1, "no completion");
        chk_bit(granted, exp, "grant state");
        chk_bit(held[i], exp, "held flag");
    endtask : do_cmd

    // Right-hand processor access; upper data bits are the inverse of bit 0.
    task automatic port_r(input logic wr, input logic [2:0] i, input logic v);
        @(negedge clk);
        sem_r_n = 1'b0;
        idx_r = i;
        rw_r_n = !wr;
        oe_r_n = wr;
        data_r = {{15{!v}}, v};
        repeat (2) @(negedge clk);
        q = dq_r;
        sem_r_n = 1'b1;
        oe_r_n = 1'b1;
        rw_r_n = 1'b1;
        data_r = ~data_r;
    endtask : port_r

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk_bit(sem_n, 1'b1, "select during reset");
        chk_bit(oe_n, 1'b1, "output enable during reset");
        chk_bit(rw_n, 1'b1, "write strobe during reset");
        chk_bit(data_oe, 1'b0, "data drive during reset");
        chk_bit(cmd_ready, 1'b0, "ready during reset");
        chk_bit(done, 1'b0, "done during reset");
        chk_word({8'h00, held}, 16'h0000, "held during reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_basic();
        do_cmd(sem_host_pkg::cmd_acquire, 3'h0, 1'b1);
        port_r(1'b0, 3'h0, 1'b0);
        chk_word(q, 16'hffff, "other side sees held");
        $display("test basic done");
    endtask : t_basic

    task automatic t_pending();
        port_r(1'b1, 3'h0, 1'b0);
        port_r(1'b0, 3'h0, 1'b0);
        chk_word(q, 16'hffff, "pending must not take");
        do_cmd(sem_host_pkg::cmd_release, 3'h0, 1'b0);
        port_r(1'b0, 3'h0, 1'b0);
        chk_word(q, 16'h0000, "pending takes over");
        do_cmd(sem_host_pkg::cmd_acquire, 3'h0, 1'b0);
        port_r(1'b1, 3'h0, 1'b1);
        port_r(1'b1, 3'h0, 1'b0);
        port_r(1'b0, 3'h0, 1'b0);
        chk_word(q, 16'h0000, "flag free after withdraw");
        port_r(1'b1, 3'h0, 1'b1);
        $display("test pending done");
    endtask : t_pending

    task automatic t_poll();
        port_r(1'b1, 3'h7, 1'b0);
        issue(sem_host_pkg::cmd_acquire, 3'h7, 1'b1);
        wait_done(40);
        chk_bit(ok, 1'b0, "done while flag held");
        port_r(1'b1, 3'h7, 1'b1);
        wait_done(60);
        chk_bit(ok, 1'b1, "poll never succeeds");
        chk_bit(granted, 1'b1, "poll grant");
        do_cmd(sem_host_pkg::cmd_release, 3'h7, 1'b0);
        $display("test poll done");
    endtask : t_poll

    task automatic t_cancel();
        port_r(1'b1, 3'h3, 1'b0);
        issue(sem_host_pkg::cmd_acquire, 3'h3, 1'b1);
        repeat (20) @(negedge clk);
        cancel = 1'b1;
        wait_done(60);
        chk_bit(ok, 1'b1, "cancel ignored");
        chk_bit(granted, 1'b0, "cancel grant");
        cancel = 1'b0;
        port_r(1'b1, 3'h3, 1'b1);
        port_r(1'b1, 3'h3, 1'b0);
        port_r(1'b0, 3'h3, 1'b0);
        chk_word(q, 16'h0000, "stale request left");
        port_r(1'b1, 3'h3, 1'b1);
        do_cmd(sem_host_pkg::cmd_acquire, 3'h3, 1'b1);
        $display("test cancel done");
    endtask : t_cancel

    initial begin
        repeat (20) @(negedge clk);
        t_reset();
        srst = 1'b0;
        for (int i = 0; i < 8; i++) port_r(1'b1, i[2:0], 1'b1);
        chk_bit(cmd_ready, 1'b0, "ready before all flags freed");
        t_basic();
        t_pending();
        t_poll();
        t_cancel();
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
